// ### card_password_lock_erase_tb.sv
`timescale 1ns/1ns
module card_password_lock_erase_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, link_clk, link_frame, link_dat;
    logic locked_flag, lock_op_failed_flag, bus_width_4, erase_busy;
    int bad_count = 0;
    int total_checks = 0;
    always #4 pclk = ~pclk;
    cple_lock cple_lock_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .link_frame(link_frame), .link_dat(link_dat), .locked_flag(locked_flag),
        .lock_op_failed_flag(lock_op_failed_flag), .bus_width_4(bus_width_4),
        .erase_busy(erase_busy));
    cple_host cple_host_inst (.link_clk(link_clk), .link_frame(link_frame),
        .link_dat(link_dat));
    // ****
    // Helpers
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        chk(pready, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] q[$]);
        cple_host_inst.send(q);
        repeat (6) @(posedge pclk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] q[$], input logic l, input logic f);
        frame(q);
        chk(locked_flag, l);
        chk(lock_op_failed_flag, f);
    endtask
    task automatic st(input int b, input logic v);
        apb(1'b0, cple_pkg::OFF_STATUS, 32'h0000_0000);
        chk(rd[b], v);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        st(cple_pkg::ST_LOCKED, 1'b0);
        apb(1'b1, cple_pkg::OFF_LENS, 32'hffff_ffff);
        apb(1'b0, cple_pkg::OFF_LENS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(er, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_fep;
        cmd('{8'h2a, 8'h1f}, 1'b0, 1'b0);
        st(cple_pkg::ST_V2, 1'b1);
        cmd('{8'h2a, 8'h11, 8'h02, 8'h41, 8'h42}, 1'b0, 1'b0);
        st(cple_pkg::ST_FEP, 1'b1);
        cmd('{8'h2a, 8'h08}, 1'b0, 1'b1);
        cmd('{8'h2a, 8'h1f}, 1'b0, 1'b1);
        cmd('{8'h2a, 8'h03}, 1'b0, 1'b1);
        $display("test erase password done");
    endtask
    task automatic t_erase;
        int n;
        cmd('{8'h2a, 8'h01, 8'h01, 8'h55}, 1'b0, 1'b0);
        cmd('{8'h2a, 8'h04, 8'h01, 8'h55}, 1'b1, 1'b0);
        frame('{8'h06, 8'h02});
        chk(bus_width_4, 1'b0);
        cmd('{8'h2a, 8'h08}, 1'b1, 1'b1);
        cmd('{8'h2a, 8'h18, 8'h01, 8'h41}, 1'b1, 1'b1);
        apb(1'b1, cple_pkg::OFF_CTRL, 32'h0000_1201);
        cmd('{8'h2a, 8'h18, 8'h02, 8'h41, 8'h42}, 1'b1, 1'b0);
        repeat (1000) @(posedge pclk);
        #1;
        chk({erase_busy, locked_flag}, 2'b11);
        apb(1'b0, cple_pkg::OFF_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_1201);
        n = 0;
        while (erase_busy !== 1'b0 && n < 60) begin
            n++;
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
        #1;
        chk({erase_busy, locked_flag}, 2'b00);
        apb(1'b0, cple_pkg::OFF_LENS, 32'h0000_0000);
        chk(rd[12:0], 13'h0200);
        apb(1'b0, cple_pkg::OFF_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test erase done");
    endtask
    task automatic t_pwp;
        cmd('{8'h2a, 8'h12, 8'h02, 8'h41, 8'h42}, 1'b0, 1'b0);
        st(cple_pkg::ST_FEP, 1'b0);
        cmd('{8'h2a, 8'h05, 8'h01, 8'h55}, 1'b1, 1'b0);
        apb(1'b1, cple_pkg::OFF_CTRL, 32'h0000_2000);
        cmd('{8'h2a, 8'h08}, 1'b1, 1'b1);
        cmd('{8'h2a, 8'h00, 8'h01, 8'h55}, 1'b0, 1'b0);
        frame('{8'h06, 8'h02});
        chk(bus_width_4, 1'b1);
        frame('{8'h00});
        chk(bus_width_4, 1'b0);
        chk(locked_flag, 1'b1);
        cmd('{8'h2a, 8'h02, 8'h01, 8'h55}, 1'b0, 1'b0);
        $display("test protect and width done");
    endtask
    task automatic t_cop;
        cmd('{8'h2a, 8'h11, 8'h02, 8'h41, 8'h42}, 1'b0, 1'b0);
        apb(1'b1, cple_pkg::OFF_CTRL, 32'h0000_2100);
        apb(1'b0, cple_pkg::OFF_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_2000);
        frame('{8'h00});
        chk(locked_flag, 1'b1);
        cmd('{8'h2a, 8'h00, 8'h01, 8'h55}, 1'b1, 1'b1);
        cmd('{8'h2a, 8'h1f}, 1'b0, 1'b0);
        st(cple_pkg::ST_COP, 1'b1);
        cmd('{8'h2a, 8'h1f}, 1'b0, 1'b1);
        $display("test unlock step done");
    endtask
    task automatic wrap_up;
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_fep();
        t_erase();
        t_pwp();
        t_cop();
        wrap_up();
    end
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule

// ### cple_host.sv
`timescale 1ns/1ns
module cple_host (
    output logic link_clk,
    output logic link_frame,
    output logic link_dat
);
    // ****
    // Frame sender, clock still between frames
    // ****
    initial begin
        link_clk = 1'b0;
        link_frame = 1'b0;
        link_dat = 1'b1;
    end
    task automatic send(input logic [7:0] q[$]);
        #43;
        link_frame = 1'b1;
        foreach (q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                link_dat = q[i][b];
                #40 link_clk = 1'b1;
                #40 link_clk = 1'b0;
            end
        end
        #40 link_frame = 1'b0;
        link_dat = ~link_dat;
        #80;
    endtask
endmodule

// ### cple_lock.sv
`timescale 1ns/1ns
// Function
// (R1) Host keeps parameter bit 4 clear in ordinary functions while erase password exists.
// (R2) With erase password stored, all lock functions blocked until 1Fh after reset.
// (R3) Erase password is stored by 1Fh followed by 11h with the password.
// (R4) 18h on locked card with both passwords: guarded erase; else failure.
// (R5) 12h clears erase password, lock state unchanged, no failure.
// (R6) 11h sets or replaces erase password, lock state kept, no failure.
// (R7) 1Fh without erase password enables newer function set, no failure.
// (R8) First 1Fh after reset enables functions; unlocks only without user password.
// (R9) Later 1Fh or 1Fh while unlocked sets failure, lock state unchanged.
// (R10) Undefined parameter values report failure and leave state unchanged.
// (R11) Replace reads old plus new password when one is stored, else new only.
// (R12) Plain erase needs a one-byte block holding only the erase bit.
// (R13) Accepted force erase clears user password and content, then unlocks.
// (R14) Force erase on an unlocked card fails with failure flag.
// (R15) Plain erase with erase password stored fails, user password kept.
// (R16) Guarded erase block is mode, length, password; only erase and option bits.
// (R17) Guarded erase runs only on matching erase password while locked.
// (R18) Guarded erase keeps erase password and its length.
// (R19) Erase password and trusted storage exclude each other.
// (R20) During erase card stays locked and keeps write protects; cleared at end. Code still takes CTRL writes during erase and never clears permanent protect.
// (R21) Permanent write protect makes force erase fail, locked and failed set.
// (R22) Bus width change rejected while locked; go-idle returns to 1-bit.
// (R23) Parameter bits: option 4, erase 3, lock 2, clear 1, set 0.
// (R24) Status bit 25 is locked flag, bit 24 is failure flag.
// (R25) After reset locked_flag whenever an erase password is stored.
// (R26) Password match needs equal length and equal bytes.
module cple_lock (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic link_frame,
    input wire logic link_dat,
    output logic locked_flag,
    output logic lock_op_failed_flag,
    output logic bus_width_4,
    output logic erase_busy
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] frm_s;
        logic [1:0] dat_s;
        logic clk_d;
        logic frm_d;
        logic [5:0] nbytes;
        logic [2:0] nbits;
        logic [7:0] sh;
        cple_pkg::cple_buf_t buffer;
        cple_pkg::cple_pw_t user_password;
        logic [4:0] user_password_length;
        cple_pkg::cple_pw_t force_erase_password;
        logic [4:0] erase_password_length;
        logic locked;
        logic failed;
        logic cop_ok;
        logic v2;
        logic bus4;
        logic erasing;
        logic [15:0] ecnt;
        logic permanent_write_protect;
        logic temporary_write_protect;
        logic wpupc;
        logic group_write_protect;
        logic trust;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } cple_state_t;

    cple_state_t st;
    cple_state_t next_st;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic pw_eq(input cple_pkg::cple_buf_t b, input int off,
                                   input cple_pkg::cple_pw_t pw, input logic [4:0] plen);
        logic eq;
        eq = 1'b1;
        for (int i = 0; i < cple_pkg::PW_MAX; i++) begin
            if (i < int'(plen) && b[off+i] != pw[i]) begin
                eq = 1'b0;
            end
        end
        return eq;
    endfunction

    function automatic cple_pkg::cple_pw_t pw_get(input cple_pkg::cple_buf_t b, input int off);
        cple_pkg::cple_pw_t r;
        r = '0;
        for (int i = 0; i < cple_pkg::PW_MAX; i++) begin
            if (off + i < cple_pkg::BUF_BYTES) begin
                r[i] = b[off+i];
            end
        end
        return r;
    endfunction

    function automatic logic repl_ok(input cple_pkg::cple_buf_t b, input logic [7:0] len,
                                     input cple_pkg::cple_pw_t pw, input logic [4:0] plen,
                                     input logic dok);
        logic [7:0] pl;
        pl = {3'b000, plen};
        return dok && pl < len && (len - pl) <= cple_pkg::PW_MAX_B
            && pw_eq(b, cple_pkg::PW_OFS, pw, plen);
    endfunction

    logic bit_edge;
    logic frm_rise;
    logic frame_end;
    logic lock_cmd;
    logic fep_set;
    logic pw_set;
    logic [7:0] pcode;
    logic [7:0] plen;
    logic data_ok;
    logic fep_match;
    logic user_match;
    logic [31:0] rd;
    logic hit;

    assign bit_edge = st.clk_s[1] & ~st.clk_d;
    assign frm_rise = st.frm_s[1] & ~st.frm_d;
    assign frame_end = st.frm_d & ~st.frm_s[1];
    assign lock_cmd = frame_end && st.nbytes > 6'd1 && st.buffer[0] == cple_pkg::OP_LOCK;
    assign fep_set = st.erase_password_length != 5'd0;
    assign pw_set = st.user_password_length != 5'd0;
    assign plen = st.buffer[2];
    assign data_ok = st.nbytes > 6'd2
        && {3'b000, st.nbytes} >= 9'd3 + {1'b0, plen};
    assign fep_match = data_ok && plen == {3'b000, st.erase_password_length} // (R26)
        && pw_eq(st.buffer, cple_pkg::PW_OFS, st.force_erase_password,
                 st.erase_password_length);
    assign user_match = data_ok && plen == {3'b000, st.user_password_length} // (R26)
        && pw_eq(st.buffer, cple_pkg::PW_OFS, st.user_password, st.user_password_length);

    // Option bit ignored in ordinary codes while no erase password exists
    always_comb begin
        pcode = st.buffer[1];
        if (!fep_set && pcode[cple_pkg::BIT_COP] && pcode != cple_pkg::P_FEP_SET // (R1)
            && pcode != cple_pkg::P_FEP_CLR && pcode != cple_pkg::P_COP_UNLOCK) begin
            pcode[cple_pkg::BIT_COP] = 1'b0;
        end
    end

    // Register read mux
    always_comb begin
        rd = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            cple_pkg::OFF_STATUS: begin
                rd[cple_pkg::ST_LOCKED] = st.locked; // (R24)
                rd[cple_pkg::ST_FAILED] = st.failed;
                rd[cple_pkg::ST_BUSY] = st.erasing;
                rd[cple_pkg::ST_BUS4] = st.bus4;
                rd[cple_pkg::ST_FEP] = fep_set;
                rd[cple_pkg::ST_COP] = st.cop_ok;
                rd[cple_pkg::ST_V2] = st.v2;
            end
            cple_pkg::OFF_CTRL: begin
                rd[cple_pkg::CT_PWP] = st.permanent_write_protect;
                rd[cple_pkg::CT_TWP] = st.temporary_write_protect;
                rd[cple_pkg::CT_WPUPC] = st.wpupc;
                rd[cple_pkg::CT_GWP] = st.group_write_protect;
                rd[cple_pkg::CT_TRUST] = st.trust;
            end
            cple_pkg::OFF_LENS: begin
                rd[4:0] = st.user_password_length;
                rd[cple_pkg::LN_FEP +: 5] = st.erase_password_length;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.clk_s = {st.clk_s[0], link_clk};
        next_st.frm_s = {st.frm_s[0], link_frame};
        next_st.dat_s = {st.dat_s[0], link_dat};
        next_st.clk_d = st.clk_s[1];
        next_st.frm_d = st.frm_s[1];
        // Link byte capture
        if (frm_rise) begin
            next_st.nbytes = 6'd0;
            next_st.nbits = 3'd0;
        end else if (bit_edge && st.frm_s[1]) begin
            next_st.sh = {st.sh[6:0], st.dat_s[1]};
            next_st.nbits = 3'(st.nbits + 3'd1);
            if (st.nbits == 3'd7 && int'(st.nbytes) < cple_pkg::BUF_BYTES) begin
                next_st.buffer[st.nbytes] = {st.sh[6:0], st.dat_s[1]};
                next_st.nbytes = 6'(st.nbytes + 6'd1);
            end
        end
        // APB slave, zero wait states
        next_st.rdy = 1'b0;
        if (psel && !penable) begin
            next_st.rdy = 1'b1;
            next_st.rdata = pwrite ? 32'h0000_0000 : rd;
            next_st.err = ~hit;
        end
        if (psel && penable && st.rdy && pwrite && paddr == cple_pkg::OFF_CTRL) begin
            next_st.permanent_write_protect = pwdata[cple_pkg::CT_PWP];
            next_st.temporary_write_protect = pwdata[cple_pkg::CT_TWP];
            next_st.wpupc = pwdata[cple_pkg::CT_WPUPC];
            next_st.group_write_protect = pwdata[cple_pkg::CT_GWP];
            next_st.trust = pwdata[cple_pkg::CT_TRUST] & ~fep_set; // (R19)
        end
        // Erase in progress
        if (st.erasing) begin
            if (st.ecnt == cple_pkg::ERASE_CYCLES - 16'd1) begin
                next_st.erasing = 1'b0;
                next_st.locked = 1'b0; // (R13)
                next_st.user_password = '0;
                next_st.user_password_length = 5'd0;
                next_st.temporary_write_protect = 1'b0; // (R20)
                next_st.wpupc = 1'b0;
                next_st.group_write_protect = 1'b0;
            end else begin
                next_st.ecnt = 16'(st.ecnt + 16'd1);
            end
        end
        // Lock command decode
        if (lock_cmd) begin
            next_st.failed = 1'b1; // (R9)
            if (st.erasing || (fep_set && !st.cop_ok && pcode != cple_pkg::P_COP_UNLOCK)) begin
                next_st.failed = 1'b1; // (R2)
            end else begin
                case (pcode)
                    cple_pkg::P_COP_UNLOCK: begin
                        if (!fep_set) begin
                            next_st.v2 = 1'b1; // (R7)
                            next_st.cop_ok = 1'b1; // (R2)
                            next_st.failed = 1'b0;
                        end else if (!st.cop_ok && st.locked) begin
                            next_st.cop_ok = 1'b1; // (R8)
                            next_st.locked = pw_set;
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_FEP_ERASE: begin // (R16)
                        if (st.locked && pw_set && fep_set && !st.permanent_write_protect && fep_match) begin
                            next_st.erasing = 1'b1; // (R4) (R17) (R18)
                            next_st.ecnt = 16'h0000;
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_FEP_CLR: begin
                        if (fep_set) begin
                            next_st.force_erase_password = '0; // (R5)
                            next_st.erase_password_length = 5'd0;
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_FEP_SET: begin
                        if (!next_st.trust && (fep_set || st.v2) // (R3) (R19)
                            && repl_ok(st.buffer, plen, st.force_erase_password,
                                       st.erase_password_length, data_ok)) begin
                            next_st.force_erase_password = pw_get(st.buffer, // (R6) (R11)
                                cple_pkg::PW_OFS + int'(st.erase_password_length));
                            next_st.erase_password_length =
                                5'(plen - {3'b000, st.erase_password_length});
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_ERASE: begin
                        if (st.nbytes == 6'd2 && st.locked && !fep_set // (R12) (R14) (R15)
                            && !st.permanent_write_protect) begin // (R21)
                            next_st.erasing = 1'b1;
                            next_st.ecnt = 16'h0000;
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_UNLOCK: begin
                        if (st.locked && pw_set && user_match) begin
                            next_st.locked = 1'b0;
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_LOCK: begin
                        if (!st.locked && pw_set && user_match) begin
                            next_st.locked = 1'b1;
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_SET, cple_pkg::P_SETLOCK: begin
                        if (repl_ok(st.buffer, plen, st.user_password, // (R11)
                                    st.user_password_length, data_ok)) begin
                            next_st.user_password = pw_get(st.buffer,
                                cple_pkg::PW_OFS + int'(st.user_password_length));
                            next_st.user_password_length =
                                5'(plen - {3'b000, st.user_password_length});
                            next_st.locked = pcode[cple_pkg::BIT_LOCK]; // (R23)
                            next_st.failed = 1'b0;
                        end
                    end
                    cple_pkg::P_CLR: begin
                        if (pw_set && user_match) begin
                            next_st.user_password = '0;
                            next_st.user_password_length = 5'd0;
                            next_st.locked = 1'b0;
                            next_st.failed = 1'b0;
                        end
                    end
                    default: begin
                        next_st.failed = 1'b1; // (R10)
                    end
                endcase
            end
        end else if (frame_end && st.nbytes != 6'd0 && st.buffer[0] == cple_pkg::OP_BUSW) begin
            next_st.failed = st.locked; // (R22)
            if (!st.locked && st.nbytes > 6'd1) begin
                next_st.bus4 = st.buffer[1][1];
            end
        end else if (frame_end && st.nbytes != 6'd0 && st.buffer[0] == cple_pkg::OP_IDLE) begin
            next_st.bus4 = 1'b0; // (R22)
            next_st.cop_ok = 1'b0;
            next_st.failed = 1'b0;
            if (!st.erasing) begin
                next_st.locked = pw_set | fep_set; // (R25)
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign locked_flag = st.locked;
    assign lock_op_failed_flag = st.failed;
    assign bus_width_4 = st.bus4;
    assign erase_busy = st.erasing;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence lock_s(logic [7:0] code);
        lock_cmd && pcode == code && !st.erasing;
    endsequence

    sequence erase_done_s;
        st.erasing ##1 !st.erasing;
    endsequence

    cop_block_a: assert property ((lock_cmd && fep_set && !st.cop_ok // (R2)
        && pcode != cple_pkg::P_COP_UNLOCK) |=> st.failed && $stable(st.locked))
        else $error("lock function not blocked before unlock step");
    cop_unlock_a: assert property ((lock_s(cple_pkg::P_COP_UNLOCK) and (fep_set // (R8)
        && !st.cop_ok && st.locked)) |=> st.cop_ok && !st.failed && st.locked == pw_set)
        else $error("first unlock step wrong");
    cop_repeat_a: assert property ((lock_s(cple_pkg::P_COP_UNLOCK) and (fep_set // (R9)
        && (st.cop_ok || !st.locked))) |=> st.failed && $stable(st.locked))
        else $error("repeated unlock step not refused");
    erase_hold_a: assert property (st.erasing |-> st.locked && $stable(st.temporary_write_protect)) // (R20)
        else $error("lock or protect dropped during erase");
    erase_end_a: assert property (erase_done_s |-> !st.locked && !pw_set // (R13)
        && !st.group_write_protect && !st.temporary_write_protect)
        else $error("erase end did not unlock and clear");
    fep_keep_a: assert property (st.erasing |=> $stable(st.erase_password_length)) // (R18)
        else $error("erase password changed by erase");
    pwp_fail_a: assert property ((lock_cmd && pcode[cple_pkg::BIT_ERASE] && st.permanent_write_protect // (R21)
        && pcode != cple_pkg::P_COP_UNLOCK && !st.erasing)
        |=> st.failed && !st.erasing && st.locked == $past(st.locked))
        else $error("erase ran under permanent protect");
    busw_lock_a: assert property ((frame_end && st.buffer[0] == cple_pkg::OP_BUSW // (R22)
        && st.nbytes != 6'd0 && st.locked) |=> st.failed && $stable(st.bus4))
        else $error("bus width changed while locked");
    trust_excl_a: assert property (!(st.trust && fep_set)) // (R19)
        else $error("erase password with trusted storage");
    unlocked_erase_a: assert property ((lock_cmd && pcode == cple_pkg::P_ERASE // (R14)
        && !st.locked) |=> st.failed && !st.erasing)
        else $error("erase accepted on unlocked card");
endmodule

// ### cple_pkg.sv
package cple_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int BUF_BYTES = 35;
    localparam int PW_MAX = 16;
    localparam int PW_OFS = 3;
    localparam logic [7:0] PW_MAX_B = 8'h10;
    typedef logic [BUF_BYTES-1:0][7:0] cple_buf_t;
    typedef logic [PW_MAX-1:0][7:0] cple_pw_t;
    // ****************************************
    // Link opcodes
    // ****************************************
    localparam logic [7:0] OP_IDLE = 8'h00;
    localparam logic [7:0] OP_BUSW = 8'h06;
    localparam logic [7:0] OP_LOCK = 8'h2a;
    // ****************************************
    // Lock parameter byte
    // ****************************************
    localparam int BIT_COP = 4;
    localparam int BIT_ERASE = 3;
    localparam int BIT_LOCK = 2;
    localparam int BIT_CLR = 1;
    localparam int BIT_SET = 0;
    localparam logic [7:0] P_UNLOCK = 8'h00;
    localparam logic [7:0] P_SET = 8'h01;
    localparam logic [7:0] P_CLR = 8'h02;
    localparam logic [7:0] P_LOCK = 8'h04;
    localparam logic [7:0] P_SETLOCK = 8'h05;
    localparam logic [7:0] P_ERASE = 8'h08;
    localparam logic [7:0] P_FEP_SET = 8'h11;
    localparam logic [7:0] P_FEP_CLR = 8'h12;
    localparam logic [7:0] P_FEP_ERASE = 8'h18;
    localparam logic [7:0] P_COP_UNLOCK = 8'h1f;
    // ****************************************
    // Registers
    // ****************************************
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_CTRL = 12'h004;
    localparam logic [11:0] OFF_LENS = 12'h008;
    localparam int ST_BUSY = 0;
    localparam int ST_BUS4 = 1;
    localparam int ST_FEP = 2;
    localparam int ST_COP = 3;
    localparam int ST_V2 = 4;
    localparam int ST_FAILED = 24;
    localparam int ST_LOCKED = 25;
    localparam int CT_GWP = 0;
    localparam int CT_TRUST = 8;
    localparam int CT_WPUPC = 9;
    localparam int CT_TWP = 12;
    localparam int CT_PWP = 13;
    localparam int LN_FEP = 8;
    // ****************************************
    // Timing
    // ****************************************
    localparam logic [15:0] ERASE_CYCLES = 16'h0400;
endpackage
